/* File: design/bdc_pkg.sv */
// Constants and types shared by the dual buck control block
package bdc_pkg;

    // Core clock period
    localparam int CLK_NS = 50;

    // Time per 10 mV ramp step for each slew code
    localparam int SLEW0_NS = 4000;
    localparam int SLEW1_NS = 2000;
    localparam int SLEW2_NS = 1000;
    localparam int SLEW3_NS = 500;

    // Same times in core clock cycles, rounded up
    localparam int SLEW0_CYC = (SLEW0_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLEW1_CYC = (SLEW1_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLEW2_CYC = (SLEW2_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLEW3_CYC = (SLEW3_NS + CLK_NS - 1) / CLK_NS;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_MODE     = 12'h004;
    localparam logic [11:0] OFS_ROUTE    = 12'h008;
    localparam logic [11:0] OFS_TRIM     = 12'h00C;
    localparam logic [11:0] OFS_STAT     = 12'h010;
    localparam logic [11:0] OFS_TGT_BASE = 12'h0D0;
    localparam logic [11:0] OFS_CEIL_A   = 12'h0E0;
    localparam logic [11:0] OFS_CEIL_B   = 12'h0E4;
    localparam logic [11:0] OFS_CODE_A   = 12'h0E8;
    localparam logic [11:0] OFS_CODE_B   = 12'h0EC;
    localparam logic [11:0] LOCK_LO      = 12'h0D0;
    localparam logic [11:0] LOCK_HI      = 12'h14F;

    // Writable bits of each register
    localparam logic [31:0] CTRL_MASK  = 32'h0000_003F;
    localparam logic [31:0] MODE_MASK  = 32'h0003_FFFF;
    localparam logic [31:0] ROUTE_MASK = 32'h0000_0FFF;
    localparam logic [31:0] TRIM_MASK  = 32'h0000_000F;
    localparam logic [31:0] CODE_MASK  = 32'h0000_007F;

    // Reset values
    localparam logic [31:0] TGT_RST  = 32'h0000_0046;
    localparam logic [31:0] CEIL_RST = 32'h0000_007F;
    localparam logic [6:0]  CODE_RST = 7'h00;

    // Control register fields, one bit per channel
    localparam int C_EN     = 0;
    localparam int C_CHOICE = 2;
    localparam int C_PINSEL = 4;

    // Mode register fields, channel B follows channel A
    localparam int M_OPM   = 0;
    localparam int M_SHED  = 4;
    localparam int M_PHSEL = 6;
    localparam int M_PDOFF = 10;
    localparam int M_SLEW  = 12;
    localparam int M_GMASK = 16;

    // Route register fields, two bits each
    localparam int R_RAMP = 0;
    localparam int R_GOOD = 4;
    localparam int R_PIN  = 8;
    localparam int PM_LVL = 0;
    localparam int PM_OUT = 1;

    // Status register fields
    localparam int S_GOOD = 0;
    localparam int S_RAMP = 2;
    localparam int S_SEL  = 4;

    // Operating mode field
    typedef enum logic [1:0] {
        BDC_MODE_AUTO,
        BDC_MODE_PFM,
        BDC_MODE_PWM,
        BDC_MODE_PWM_ALT
    } bdc_mode_t;

endpackage

/* File: design/bdc_top.sv */
// Dual buck digital control: targets, ramps, power good, pins, phases
//
// Function
// - 7-bit code, 10 mV steps, 0.3 to 1.57 V
// - Two targets per channel, pin or register choice
// - Rewriting active target starts a ramp
// - Toggling the choice bit starts a ramp
// - Step time 4, 2, 1, 0.5 us per code
// - Ramp flag routable to either pin, output mode
// - Ramp flag tracks digital ramp only
// - Power good with set and hysteresis clear
// - Power good held during ramp when masked
// - Power good readable in status register
// - Power good routable to either pin
// - Mode write overrides pin until good changes
// - Disabled channel pulls down its selected phases
// - No pull-down while device is off
// - Oscillator trim field driven to oscillator
// - Mode field picks PWM, PFM or auto
// - Phase shedding in PWM when enabled
// - Phase select caps active phases always
// - Auto mode follows load between PWM, PFM
// - Ramps run in PWM
// - Ramp flag high for whole transition
// - Ceiling register clamps the applied target
// - Lock blocks writes to 0xD0 through 0x14F
// - Enable defaults to first target under register choice
`timescale 1ns/1ps
module bdc_top
    import bdc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Hardware controls
    input  wire logic        dev_on,
    input  wire logic        volt_lock,
    input  wire logic [1:0]  sel_pin,
    // Analogue monitor results, bit per channel
    input  wire logic [1:0]  pg_above,
    input  wire logic [1:0]  pg_below,
    input  wire logic [1:0]  load_heavy,
    input  wire logic [1:0]  load_light,
    // Converter controls
    output logic      [6:0]  chan_a_code,
    output logic      [6:0]  chan_b_code,
    output logic      [1:0]  pwm_on,
    output logic      [3:0]  chan_a_phases,
    output logic      [3:0]  chan_b_phases,
    output logic      [3:0]  chan_a_pulldown,
    output logic      [3:0]  chan_b_pulldown,
    output logic      [3:0]  oscillator_trim,
    // General-purpose output pins
    output logic             gp_pin_two_o,
    output logic             gp_pin_two_oe_n,
    output logic             gp_pin_three_o,
    output logic             gp_pin_three_oe_n
);

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction

    // Interval reload for a slew code
    function automatic logic [6:0] slew_reload(input logic [1:0] f);
        logic [6:0] r;
        r = 7'(SLEW0_CYC - 1);
        unique case (f)
            2'b00: r = 7'(SLEW0_CYC - 1);
            2'b01: r = 7'(SLEW1_CYC - 1);
            2'b10: r = 7'(SLEW2_CYC - 1);
            2'b11: r = 7'(SLEW3_CYC - 1);
        endcase
        return r;
    endfunction

    // Phases allowed by a phase select field
    function automatic logic [3:0] phase_mask(input logic [1:0] f);
        logic [3:0] r;
        r = 4'h1;
        unique case (f)
            2'b00: r = 4'h1;
            2'b01: r = 4'h3;
            2'b10: r = 4'h7;
            2'b11: r = 4'hF;
        endcase
        return r;
    endfunction

    // Route field points at pin p (01 pin two, 10 pin three)
    function automatic logic routed(input logic [1:0] f, input int p);
        return f == 2'(p + 1);
    endfunction

    // Software registers
    logic [31:0] ctrl_q;          // Enables and choices
    logic [31:0] ctrl_d;          // Next control value
    logic [31:0] mode_q;          // Modes, phases, slew, masks
    logic [31:0] route_q;         // Pin routing and pin modes
    logic [31:0] route_w;         // Route value after a write
    logic [31:0] trim_q;          // Oscillator trim
    logic [31:0] tgt_q [4];       // Targets, index 2*chan+choice
    logic [31:0] ceil_q [2];      // Per-channel ceilings
    // Bus handshake
    logic        ack_q;           // One-cycle acknowledge
    logic [31:0] dat_q;           // Registered read data
    logic [31:0] rd_d;            // Read mux
    logic        req;             // New request this cycle
    logic        wr_ok;           // Write allowed this cycle
    // Channel state
    logic [6:0]  code_q [2];      // Applied voltage code
    logic [6:0]  tmr_q [2];       // Slew interval countdown
    logic        ramp_q [2];      // Ramp in progress
    logic        good_q [2];      // Power good
    logic        good_prev_q [2]; // Power good one cycle ago
    logic        pwm_q [2];       // PWM running
    logic [3:0]  ph_q [2];        // Active phases
    logic [3:0]  pd_q [2];        // Pull-downs on
    logic        eff_sel [2];     // Effective target choice
    // Pin state
    logic        lvl_q [2];       // Level held for each pin
    logic        pin_o_q [2];     // Driven pin level
    logic        pin_oe_n_q [2];  // Pin enable, low drives

    // Bus decode
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    // Locked range rejects writes silently, ack still given
    assign wr_ok = req && wb_we_i &&
                   !(volt_lock && wb_adr_i >= LOCK_LO && wb_adr_i <= LOCK_HI);
    assign route_w = merge(route_q, wb_dat_i, wb_sel_i) & ROUTE_MASK;

    // Acknowledge and read data, one cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req;
            if (req && !wb_we_i)
                dat_q <= rd_d;
        end
    end

    // Read mux, unmapped reads return zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CTRL:                 rd_d = ctrl_q;
            OFS_MODE:                 rd_d = mode_q;
            OFS_ROUTE:                rd_d = route_q;
            OFS_TRIM:                 rd_d = trim_q;
            OFS_TGT_BASE:             rd_d = tgt_q[0];
            OFS_TGT_BASE + 12'h004:   rd_d = tgt_q[1];
            OFS_TGT_BASE + 12'h008:   rd_d = tgt_q[2];
            OFS_TGT_BASE + 12'h00C:   rd_d = tgt_q[3];
            OFS_CEIL_A:               rd_d = ceil_q[0];
            OFS_CEIL_B:               rd_d = ceil_q[1];
            OFS_CODE_A:               rd_d = {25'h0, code_q[0]};
            OFS_CODE_B:               rd_d = {25'h0, code_q[1]};
            OFS_STAT:
            begin
                rd_d[S_GOOD]   = good_q[0];
                rd_d[S_GOOD+1] = good_q[1];
                rd_d[S_RAMP]   = ramp_q[0];
                rd_d[S_RAMP+1] = ramp_q[1];
                rd_d[S_SEL]    = eff_sel[0];
                rd_d[S_SEL+1]  = eff_sel[1];
            end
            default:                  rd_d = 32'h0000_0000;
        endcase
    end

    // Control write; enabling a channel under register choice falls back to its first target
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ok && wb_adr_i == OFS_CTRL)
        begin
            ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i) & CTRL_MASK;
            for (int c = 0; c < 2; c++)
            begin
                if (!ctrl_q[C_EN+c] && ctrl_d[C_EN+c] && !ctrl_d[C_PINSEL+c])
                    ctrl_d[C_CHOICE+c] = 1'b0;
            end
        end
    end

    // Control, mode, route and trim registers
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            ctrl_q  <= 32'h0000_0000;
            mode_q  <= 32'h0000_0000;
            route_q <= 32'h0000_0000;
            trim_q  <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            if (wr_ok && wb_adr_i == OFS_MODE)
                mode_q <= merge(mode_q, wb_dat_i, wb_sel_i) & MODE_MASK;
            if (wr_ok && wb_adr_i == OFS_ROUTE)
                route_q <= route_w;
            if (wr_ok && wb_adr_i == OFS_TRIM)
                trim_q <= merge(trim_q, wb_dat_i, wb_sel_i) & TRIM_MASK;
        end
    end

    // Target registers, two per channel
    for (genvar k = 0; k < 4; k++)
    begin : gen_tgt
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
                tgt_q[k] <= TGT_RST;
            else if (wr_ok && wb_adr_i == OFS_TGT_BASE + 12'(4 * k))
                tgt_q[k] <= merge(tgt_q[k], wb_dat_i, wb_sel_i) & CODE_MASK;
        end
    end

    // Per-channel ramp, power good, mode and phase logic
    for (genvar i = 0; i < 2; i++)
    begin : gen_ch
        logic [6:0] goal;   // Clamped active target
        logic [6:0] raw;    // Selected target before clamp
        logic       en;     // Channel enabled
        logic       ramping;
        logic       pwm_d;
        logic [3:0] full;   // Phases allowed by the cap

        assign en      = ctrl_q[C_EN+i];
        assign eff_sel[i] = ctrl_q[C_PINSEL+i] ? sel_pin[i] : ctrl_q[C_CHOICE+i];
        assign raw     = tgt_q[2*i + int'(eff_sel[i])][6:0];
        // On an enabled channel, any change of the goal, by rewrite or by choice, opens a ramp; a disabled one jumps
        assign goal    = (raw > ceil_q[i][6:0]) ? ceil_q[i][6:0] : raw;
        assign ramping = en && (code_q[i] != goal);
        assign full    = phase_mask(mode_q[M_PHSEL+2*i +: 2]);

        // Ceiling register, locked like the targets
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
                ceil_q[i] <= CEIL_RST;
            else if (wr_ok && wb_adr_i == (i == 0 ? OFS_CEIL_A : OFS_CEIL_B))
                ceil_q[i] <= merge(ceil_q[i], wb_dat_i, wb_sel_i) & CODE_MASK;
        end

        // Slew timer; idle reload makes the first step a full interval
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
                tmr_q[i] <= 7'h00;
            else if (!ramping || tmr_q[i] == 7'h00)
                tmr_q[i] <= slew_reload(mode_q[M_SLEW+2*i +: 2]);
            else
                tmr_q[i] <= tmr_q[i] - 7'h01;
        end

        // Applied code walks one step from where it is toward the goal
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
                code_q[i] <= CODE_RST;
            else if (!en)
                code_q[i] <= goal;
            else if (ramping && tmr_q[i] == 7'h00)
            begin
                // Goal is read live, so a new target redirects mid-ramp
                if (code_q[i] < goal)
                    code_q[i] <= code_q[i] + 7'h01;
                else
                    code_q[i] <= code_q[i] - 7'h01;
            end
        end

        // Ramp flag from the digital walk only, never the analogue output
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
                ramp_q[i] <= 1'b0;
            else
                ramp_q[i] <= ramping;
        end

        // Power good with hysteresis; optional hold during ramps
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
            begin
                good_q[i]      <= 1'b0;
                good_prev_q[i] <= 1'b0;
            end
            else
            begin
                good_prev_q[i] <= good_q[i];
                if (!en)
                    good_q[i] <= 1'b0;
                else if (mode_q[M_GMASK+i] && ramp_q[i])
                    good_q[i] <= good_q[i];
                else if (pg_above[i])
                    good_q[i] <= 1'b1;
                else if (pg_below[i])
                    good_q[i] <= 1'b0;
            end
        end

        // Operating mode; ramps force PWM
        always_comb
        begin
            pwm_d = 1'b1;
            unique case (bdc_mode_t'(mode_q[M_OPM+2*i +: 2]))
                BDC_MODE_AUTO:    pwm_d = !load_light[i];
                BDC_MODE_PFM:     pwm_d = 1'b0;
                BDC_MODE_PWM:     pwm_d = 1'b1;
                BDC_MODE_PWM_ALT: pwm_d = 1'b1;
            endcase
            if (ramping)
                pwm_d = 1'b1;
        end

        // Mode, phases and pull-downs, registered to the outputs
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
            begin
                pwm_q[i] <= 1'b0;
                ph_q[i]  <= 4'h0;
                pd_q[i]  <= 4'h0;
            end
            else
            begin
                pwm_q[i] <= en && pwm_d;
                // Shedding only narrows inside the cap
                if (!en)
                    ph_q[i] <= 4'h0;
                else if (mode_q[M_SHED+i] && pwm_d && !ramping && !load_heavy[i])
                    ph_q[i] <= 4'h1 & full;
                else
                    ph_q[i] <= full;
                if (dev_on && !en && !mode_q[M_PDOFF+i])
                    pd_q[i] <= full;
                else
                    pd_q[i] <= 4'h0;
            end
        end
    end

    // General-purpose pin drivers
    for (genvar p = 0; p < 2; p++)
    begin : gen_pin
        logic has_ramp;  // Some ramp flag routed here
        logic ramp_lvl;  // Routed ramp flags combined
        logic gchg;      // Routed power good changed
        logic gval;      // New power good value

        always_comb
        begin
            has_ramp = 1'b0;
            ramp_lvl = 1'b0;
            gchg     = 1'b0;
            gval     = 1'b0;
            for (int c = 0; c < 2; c++)
            begin
                if (routed(route_q[R_RAMP+2*c +: 2], p))
                begin
                    has_ramp = 1'b1;
                    ramp_lvl = ramp_lvl | ramp_q[c];
                end
                if (routed(route_q[R_GOOD+2*c +: 2], p) && good_q[c] != good_prev_q[c])
                begin
                    gchg = 1'b1;
                    gval = good_q[c];
                end
            end
        end

        // Held level: a mode write sets it, a good change wins over it
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
                lvl_q[p] <= 1'b0;
            else if (gchg)
                lvl_q[p] <= gval;
            else if (wr_ok && wb_adr_i == OFS_ROUTE)
                lvl_q[p] <= route_w[R_PIN+2*p+PM_LVL];
        end

        // Pin drives only when software made it an output
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
            begin
                pin_o_q[p]    <= 1'b0;
                pin_oe_n_q[p] <= 1'b1;
            end
            else
            begin
                pin_o_q[p]    <= has_ramp ? ramp_lvl : lvl_q[p];
                pin_oe_n_q[p] <= !route_q[R_PIN+2*p+PM_OUT];
            end
        end
    end

    // Outputs, all from flip-flops
    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = dat_q;
    assign chan_a_code       = code_q[0];
    assign chan_b_code       = code_q[1];
    assign pwm_on            = {pwm_q[1], pwm_q[0]};
    assign chan_a_phases     = ph_q[0];
    assign chan_b_phases     = ph_q[1];
    assign chan_a_pulldown   = pd_q[0];
    assign chan_b_pulldown   = pd_q[1];
    assign oscillator_trim   = trim_q[3:0];
    assign gp_pin_two_o      = pin_o_q[0];
    assign gp_pin_two_oe_n   = pin_oe_n_q[0];
    assign gp_pin_three_o    = pin_o_q[1];
    assign gp_pin_three_oe_n = pin_oe_n_q[1];

endmodule // bdc_top

/* File: tb/bdc_top_asserts.sv */
// Port checker for the dual buck control block
`timescale 1ns/1ps
module bdc_top_chk
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Converter side
    input wire logic        dev_on,
    input wire logic [6:0]  chan_a_code,
    input wire logic [1:0]  pwm_on,
    input wire logic [3:0]  chan_a_phases,
    input wire logic [3:0]  chan_a_pulldown
);
    // Single domain
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Answer one cycle after the take, one cycle long
    property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_take: assert property (p_take) else $error("ack missing");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_cause: assert property (p_cause) else $error("ack unasked");
    // Read data moves only with a read answer
    property p_hold; !(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // Pull-downs
    property p_pdoff; !dev_on |=> chan_a_pulldown == 4'h0; endproperty
    a_pdoff: assert property (p_pdoff) else $error("pull-down while off");
    property p_pdph; chan_a_pulldown != 4'h0 |-> chan_a_phases == 4'h0; endproperty
    a_pdph: assert property (p_pdph) else $error("pull-down on live rail");
    // Running rail moves one code per step, at least nine cycles apart
    property p_step; $changed(chan_a_code) && pwm_on[0]
        |-> 7'(chan_a_code - $past(chan_a_code)) inside {7'h01, 7'h7F}; endproperty
    a_step: assert property (p_step) else $error("step not one code");
    property p_gap; $changed(chan_a_code) && pwm_on[0] |=> $stable(chan_a_code) [*8]; endproperty
    a_gap: assert property (p_gap) else $error("steps too close");
endmodule // bdc_top_chk
bind bdc_top bdc_top_chk u_chk (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .dev_on(dev_on), .chan_a_code(chan_a_code), .pwm_on(pwm_on),
    .chan_a_phases(chan_a_phases), .chan_a_pulldown(chan_a_pulldown));

/* File: tb/bdc_host.sv */
// Host model: classic Wishbone master for register traffic
`timescale 1ns/1ps
module bdc_host
(
    // Clock
    input  wire logic        core_clk,
    // Request side
    output logic      [11:0] adr,
    output logic      [31:0] wdat,
    output logic             we,
    output logic      [3:0]  sel,
    output logic             cyc,
    output logic             stb,
    // Answer side and hang flag
    input  wire logic [31:0] rdat,
    input  wire logic        ack,
    output logic             tmo
);
    // Idle bus from time zero
    initial
    begin
        {adr, wdat, we, sel, cyc, stb, tmo} = '0;
    end
    // One cycle, held until ack; call just after an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        {adr, wdat, we, sel} <= {a, d, w, 4'hF};
        {cyc, stb} <= 2'b11;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 64);
        q = rdat;
        tmo <= (n >= 64);
        {cyc, stb, we} <= 3'b000;
        // Released data shows the inverse
        wdat <= ~d;
        @(posedge core_clk);
    endtask
endmodule // bdc_host

/* File: tb/bdc_top_test.sv */
// Scenario testbench for the dual buck control block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module bdc_top_test
    import bdc_pkg::*;
;
    // Stimulus
    logic        core_clk = 1'b0, rstn = 1'b0, dev_on = 1'b1, volt_lock = 1'b0;
    logic [1:0]  sel_pin = 2'b00, pg_above = 2'b00, pg_below = 2'b00;
    logic [1:0]  heavy = 2'b00, light = 2'b00;
    // Bus wires and results
    logic [11:0] adr;
    logic [31:0] wdat, rdat, q;
    logic        we, cyc, stb, ack, tmo, p2, p2_oe_n, p3, p3_oe_n;
    logic [3:0]  sel, ph_a, ph_b, pd_a, pd_b, trim;
    logic [6:0]  code_a, code_b;
    logic [1:0]  pwm;
    int          checks = 0, miscompares = 0;
    // Step interval per slew code; mode table {heavy, light} and {pwm, phases}
    int          iv [4] = '{SLEW0_CYC, SLEW1_CYC, SLEW2_CYC, SLEW3_CYC};
    logic [31:0] mw [5] = '{32'h0000_00C0, 32'h0000_00C0, 32'h0000_00C1, 32'h0000_00D2,
                            32'h0000_00D2};
    logic [1:0]  ld [5] = '{2'b01, 2'b00, 2'b00, 2'b00, 2'b10};
    logic [4:0]  ex [5] = '{5'h0F, 5'h1F, 5'h0F, 5'h11, 5'h1F};
    always #25 core_clk = ~core_clk;
    bdc_top dut (.core_clk(core_clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .dev_on(dev_on), .volt_lock(volt_lock), .sel_pin(sel_pin),
        .pg_above(pg_above), .pg_below(pg_below), .load_heavy(heavy), .load_light(light),
        .chan_a_code(code_a), .chan_b_code(code_b), .pwm_on(pwm), .chan_a_phases(ph_a),
        .chan_b_phases(ph_b), .chan_a_pulldown(pd_a), .chan_b_pulldown(pd_b),
        .oscillator_trim(trim), .gp_pin_two_o(p2), .gp_pin_two_oe_n(p2_oe_n),
        .gp_pin_three_o(p3), .gp_pin_three_oe_n(p3_oe_n));
    bdc_host host (.core_clk(core_clk), .adr(adr), .wdat(wdat), .we(we), .sel(sel),
        .cyc(cyc), .stb(stb), .rdat(rdat), .ack(ack), .tmo(tmo));
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic hang();
        miscompares++;
        conclude();
    endtask
    always @(posedge tmo) hang();
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0000_0000, q);
    endtask
    // Edges until the rail code moves or equals v
    task automatic wait_chg(output int n);
        logic [6:0] o;
        o = code_a;
        for (n = 0; code_a === o && n < 4000; n++) @(posedge core_clk);
        if (n >= 4000) hang();
    endtask
    task automatic wait_code(input logic [6:0] v);
        int n;
        for (n = 0; code_a !== v && n < 4000; n++) @(posedge core_clk);
        if (n >= 4000) hang();
    endtask
    // Reset values, unmapped read, trim
    task automatic t_reset();
        `CHK(code_a, 7'h00)
        `CHK(p2_oe_n, 1'b1)
        rstn <= 1'b1;
        tick(3);
        `CHK({code_a, code_b}, {2{TGT_RST[6:0]}})
        rd(OFS_CEIL_A);
        `CHK(q, CEIL_RST)
        rd(12'h020);
        `CHK(q, 32'h0000_0000)
        wr(OFS_TRIM, 32'h0000_0005);
        tick(2);
        `CHK(trim, 4'h5)
    endtask
    // Two-step ramps per slew code, flag on pin three, redirect
    task automatic t_slew();
        int n;
        logic [6:0] t;
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_ROUTE, 32'h0000_0802);
        t = 7'h46;
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_MODE, 32'h0000_0002 | (32'(s) << M_SLEW));
            t = t + 7'h02;
            wr(OFS_TGT_BASE, {25'h0, t});
            wait_chg(n);
            `CHK(p3_oe_n, 1'b0)
            `CHK({p3, pwm[0]}, 2'b11)
            wait_chg(n);
            `CHK(n, iv[s])
            `CHK(code_a, t)
            tick(3);
            `CHK(p3, 1'b0)
        end
        wr(OFS_TGT_BASE, 32'h0000_0060);
        wait_chg(n);
        wr(OFS_TGT_BASE, {25'h0, t});
        wait_chg(n);
        `CHK(code_a, t)
    endtask
    // Enable default, toggle under ceiling, pin choice, lock
    task automatic t_sel();
        wr(OFS_TGT_BASE, 32'h0000_0048);
        wait_code(7'h48);
        wr(OFS_CEIL_A, 32'h0000_004A);
        wr(OFS_TGT_BASE + 12'h004, 32'h0000_0050);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0005);
        rd(OFS_STAT);
        `CHK(q[S_SEL], 1'b0)
        wr(OFS_CTRL, 32'h0000_0005);
        wait_code(7'h4A);
        tick(40);
        `CHK(code_a, 7'h4A)
        wr(OFS_CTRL, 32'h0000_0015);
        wait_code(7'h48);
        `CHK(code_a, 7'h48)
        volt_lock <= 1'b1;
        wr(OFS_TGT_BASE, 32'h0000_0055);
        rd(OFS_TGT_BASE);
        `CHK(q, 32'h0000_0048)
        volt_lock <= 1'b0;
    endtask
    // Power good on pin two, hysteresis, mode write override
    task automatic t_good();
        wr(OFS_ROUTE, 32'h0000_0210);
        pg_above <= 2'b01;
        tick(4);
        `CHK({p2, p2_oe_n}, 2'b10)
        wr(OFS_ROUTE, 32'h0000_0210);
        pg_above <= 2'b00;
        tick(4);
        `CHK(p2, 1'b0)
        rd(OFS_STAT);
        `CHK(q[S_GOOD], 1'b1)
        pg_below <= 2'b01;
        tick(4);
        rd(OFS_STAT);
        `CHK(q[S_GOOD], 1'b0)
        pg_below <= 2'b00;
        pg_above <= 2'b01;
        tick(4);
        `CHK(p2, 1'b1)
    endtask
    // Pull-downs by phase cap, device off, disable bit
    task automatic t_pull();
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_MODE, 32'h0000_0040);
        tick(3);
        `CHK({pd_a, pd_b}, 8'h31)
        dev_on <= 1'b0;
        tick(3);
        `CHK(pd_a, 4'h0)
        dev_on <= 1'b1;
        wr(OFS_MODE, 32'h0000_0440);
        tick(3);
        `CHK(pd_a, 4'h0)
    endtask
    // Auto, PFM and PWM modes with light and heavy load
    task automatic t_phase();
        wr(OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 5; i++)
        begin
            {heavy[0], light[0]} <= ld[i];
            wr(OFS_MODE, mw[i]);
            tick(3);
            `CHK({pwm, ph_a, ph_b}, {1'b0, ex[i], 4'h0})
        end
    endtask
    initial
    begin
        tick(20);
        t_reset();
        t_slew();
        t_sel();
        t_good();
        t_pull();
        t_phase();
        conclude();
    end
endmodule // bdc_top_test
